//--- logic/cvs_charge_voltage_setpoint.sv
// charge voltage setpoint register pair with range check and strap default
//
// Contract
// RULE1 - setpoints from 1.024 V to 23.000 V accepted, 8 mV per step
// RULE2 - out-of-range writes discarded, previous setpoint kept
// RULE3 - reset default from cell strap: 4200/8400/12600/16800/21000 mV
// RULE4 - charging starts on current-target write after input power good
// RULE5 - host writes voltage before current target for non-4.2 V cells
// RULE6 - zero write keeps setpoint and clears charge current target
// RULE7 - field bits 11..5 in high byte 6..0, bits 4..0 in low 7..3
// RULE8 - high byte field bits weigh 16384 mV down to 256 mV
// RULE9 - low byte field bits weigh 128 mV down to 8 mV
// RULE10 - reserved top bit of high byte set means invalid write
// RULE11 - reserved low three bits of low byte never affect setpoint
// RULE12 - invalid write changes neither byte nor charge current target
`timescale 1ns/1ps
module cvs_charge_voltage_setpoint (
    input wire logic clock,
    input wire logic nrst,
    input wire cvs_pkg::cvs_write_t hostWrite,
    input wire logic [7:0] readAddr,
    input wire logic [2:0] cellCountStrap,
    input wire logic inputPowerGood,
    input wire logic currentTargetWritten,
    output logic [7:0] readData,
    output logic [cvs_pkg::CVS_FIELD_W-1:0] chargeVoltageTarget,
    output logic [cvs_pkg::CVS_MV_W-1:0] chargeVoltageMv,
    output logic clearCurrentTarget,
    output logic chargeEnable
);
    import cvs_pkg::*;

    cvs_state_t state_reg;
    logic [CVS_FIELD_W-1:0] field_reg;
    logic [CVS_FIELD_W-1:0] field_next;
    logic [CVS_LOW_FIELD_W-1:0] lowStage_reg;
    logic [CVS_MV_W-1:0] mv_reg;
    logic [7:0] rd_reg;
    logic clr_reg;
    logic chg_reg;

    logic [CVS_FIELD_W-1:0] candField;
    logic [CVS_MV_W-1:0] candMv;
    logic candZero;
    logic candInRange;
    logic candInvalid;
    logic highWrite;
    logic lowWrite;
    logic commit;
    logic zeroWrite;
    logic [CVS_MV_W-1:0] defaultMv;

    function automatic logic [CVS_MV_W-1:0] strap_default(
        input logic [2:0] cells
    );
        case (cells)
            CVS_CELLS_2: strap_default = CVS_DEF2_MV;
            CVS_CELLS_3: strap_default = CVS_DEF3_MV;
            CVS_CELLS_4: strap_default = CVS_DEF4_MV;
            CVS_CELLS_5: strap_default = CVS_DEF5_MV;
            // unlisted strap codes fall back to the single-cell voltage
            default: strap_default = CVS_DEF1_MV;
        endcase
    endfunction : strap_default

    assign highWrite = hostWrite.valid && (hostWrite.addr == CVS_ADDR_HIGH);
    assign lowWrite = hostWrite.valid && (hostWrite.addr == CVS_ADDR_LOW);
    // the pair commits on the high byte so a half-written word never lands
    assign candField = {hostWrite.data[CVS_HIGH_FIELD_W-1:0],
        lowStage_reg}; // RULE7
    assign defaultMv = strap_default(cellCountStrap); // RULE3

    cvs_decode decoder (
        .field(candField),
        .rsvdBit(hostWrite.data[CVS_HIGH_RSVD_POS]),
        .millivolts(candMv),
        .isZero(candZero),
        .inRange(candInRange),
        .isInvalid(candInvalid)
    );

    assign zeroWrite = highWrite && !candInvalid && candZero; // RULE6 RULE12
    assign commit = highWrite && !candInvalid && !candZero &&
        candInRange; // RULE2 RULE12

    always_comb begin
        field_next = field_reg;
        if (state_reg == CVS_ST_LOAD) begin
            field_next = CVS_FIELD_W'(defaultMv / CVS_STEP_MV); // RULE3
        end else if (commit) begin
            field_next = candField; // RULE1
        end
    end

    // strap is caught on the first edge after reset release
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= CVS_ST_LOAD;
        end else begin
            case (state_reg)
                CVS_ST_LOAD: state_reg <= CVS_ST_RUN;
                CVS_ST_RUN: state_reg <= CVS_ST_RUN;
                default: state_reg <= CVS_ST_LOAD;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            field_reg <= CVS_FIELD_ZERO;
            mv_reg <= CVS_MV_W'(0);
        end else begin
            field_reg <= field_next;
            mv_reg <= CVS_MV_W'({4'h0, field_next} * CVS_STEP_MV);
        end
    end

    // low byte stage; reserved bits 2..0 are dropped here
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lowStage_reg <= CVS_LOW_FIELD_W'(0);
        end else if (state_reg == CVS_ST_LOAD) begin
            lowStage_reg <= field_next[CVS_LOW_FIELD_W-1:0];
        end else if (lowWrite) begin
            lowStage_reg <= hostWrite.data[7:CVS_LOW_POS]; // RULE11
        end else if (highWrite && !commit) begin
            // a refused word also rolls back the staged low byte
            lowStage_reg <= field_reg[CVS_LOW_FIELD_W-1:0]; // RULE2 RULE12
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            clr_reg <= 1'b0;
        end else begin
            clr_reg <= zeroWrite; // RULE6
        end
    end

    // a zero write wins over a same-cycle current write: charging stops
    always_ff @(posedge clock) begin
        if (!nrst) begin
            chg_reg <= 1'b0;
        end else if (zeroWrite || !inputPowerGood) begin
            chg_reg <= 1'b0; // RULE6
        end else if (currentTargetWritten && state_reg == CVS_ST_RUN) begin
            chg_reg <= 1'b1; // RULE4 RULE5
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_reg <= CVS_BYTE_ZERO;
        end else if (readAddr == CVS_ADDR_HIGH) begin
            rd_reg <= {1'b0, field_next[CVS_FIELD_W-1:CVS_LOW_FIELD_W]};
        end else if (readAddr == CVS_ADDR_LOW) begin
            rd_reg <= {field_next[CVS_LOW_FIELD_W-1:0], 3'h0};
        end else begin
            rd_reg <= CVS_BYTE_ZERO;
        end
    end

    assign readData = rd_reg;
    assign chargeVoltageTarget = field_reg;
    assign chargeVoltageMv = mv_reg;
    assign clearCurrentTarget = clr_reg;
    assign chargeEnable = chg_reg;
endmodule : cvs_charge_voltage_setpoint

//--- logic/cvs_decode.sv
// decodes a candidate setpoint field into millivolts and checks its range
`timescale 1ns/1ps
module cvs_decode (
    input wire logic [cvs_pkg::CVS_FIELD_W-1:0] field,
    input wire logic rsvdBit,
    output logic [cvs_pkg::CVS_MV_W-1:0] millivolts,
    output logic isZero,
    output logic inRange,
    output logic isInvalid
);
    import cvs_pkg::*;

    // the field LSB weighs 8 mV, so bit 11 adds 16384 and bit 0 adds 8
    always_comb begin
        millivolts = CVS_MV_W'({4'h0, field} * CVS_STEP_MV); // RULE8 RULE9
        isZero = (field == CVS_FIELD_ZERO);
        inRange = (millivolts >= CVS_MIN_MV) &&
            (millivolts <= CVS_MAX_MV); // RULE1
        isInvalid = rsvdBit; // RULE10
    end
endmodule : cvs_decode

//--- logic/cvs_pkg.sv
// constants and types for the charge voltage setpoint register pair
package cvs_pkg;
    localparam logic [7:0] CVS_ADDR_LOW = 8'h04;
    localparam logic [7:0] CVS_ADDR_HIGH = 8'h05;

    localparam int CVS_FIELD_W = 12;
    localparam int CVS_MV_W = 16;
    localparam int CVS_LOW_FIELD_W = 5;
    localparam int CVS_HIGH_FIELD_W = 7;
    localparam int CVS_LOW_POS = 3;
    localparam int CVS_HIGH_RSVD_POS = 7;

    localparam logic [15:0] CVS_STEP_MV = 16'h0008;
    localparam logic [15:0] CVS_MIN_MV = 16'h0400;
    localparam logic [15:0] CVS_MAX_MV = 16'h59d8;

    localparam logic [15:0] CVS_DEF1_MV = 16'h1068;
    localparam logic [15:0] CVS_DEF2_MV = 16'h20d0;
    localparam logic [15:0] CVS_DEF3_MV = 16'h3138;
    localparam logic [15:0] CVS_DEF4_MV = 16'h41a0;
    localparam logic [15:0] CVS_DEF5_MV = 16'h5208;

    localparam logic [2:0] CVS_CELLS_1 = 3'h1;
    localparam logic [2:0] CVS_CELLS_2 = 3'h2;
    localparam logic [2:0] CVS_CELLS_3 = 3'h3;
    localparam logic [2:0] CVS_CELLS_4 = 3'h4;
    localparam logic [2:0] CVS_CELLS_5 = 3'h5;

    localparam logic [7:0] CVS_BYTE_ZERO = 8'h00;
    localparam logic [11:0] CVS_FIELD_ZERO = 12'h000;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } cvs_write_t;

    typedef enum logic [0:0] {
        CVS_ST_LOAD = 1'b0,
        CVS_ST_RUN = 1'b1
    } cvs_state_t;
endpackage : cvs_pkg

//--- tb/cvs_host_model.sv
// host side byte writer for the setpoint pair
`timescale 1ns/1ps
module cvs_host_model (
    input wire logic clock,
    output cvs_pkg::cvs_write_t hostWrite
);
    import cvs_pkg::*;
    initial hostWrite = '{1'b0, 8'h00, 8'h00};
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 hostWrite = '{1'b1, a, d};
        @(posedge clock);
        // released lines flip, so stale data cannot pass
        #1 hostWrite = '{1'b0, ~a, ~d};
    endtask : wr
    task automatic wv(input logic [15:0] w);
        wr(CVS_ADDR_LOW, w[7:0]);
        wr(CVS_ADDR_HIGH, w[15:8]);
    endtask : wv
endmodule : cvs_host_model

//--- tb/cvs_sva.sv
// port assertions for the setpoint pair
`timescale 1ns/1ps
module cvs_sva (
    input wire logic clock,
    input wire logic nrst,
    input wire cvs_pkg::cvs_write_t hostWrite,
    input wire logic inputPowerGood,
    input wire logic currentTargetWritten,
    input wire logic [cvs_pkg::CVS_FIELD_W-1:0] chargeVoltageTarget,
    input wire logic [cvs_pkg::CVS_MV_W-1:0] chargeVoltageMv,
    input wire logic clearCurrentTarget,
    input wire logic chargeEnable
);
    import cvs_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire logic hiWr = hostWrite.valid && hostWrite.addr == CVS_ADDR_HIGH;
    wire logic loWr = hostWrite.valid && hostWrite.addr == CVS_ADDR_LOW;
    range_held_a: assert property ($past(nrst) |->
        chargeVoltageMv >= CVS_MIN_MV && chargeVoltageMv <= CVS_MAX_MV)
        else $error("range");
    mv_weight_a: assert property (chargeVoltageMv ==
        {1'h0, chargeVoltageTarget, 3'h0}) else $error("weight");
    rsvd_reject_a: assert property (hiWr && hostWrite.data[7] |=>
        $stable(chargeVoltageTarget) && !clearCurrentTarget)
        else $error("rsvd");
    zero_keep_a: assert property (clearCurrentTarget |->
        $stable(chargeVoltageTarget) && !chargeEnable) else $error("zero");
    clear_cause_a: assert property (clearCurrentTarget |->
        $past(hiWr && !hostWrite.data[7])) else $error("clear");
    start_cause_a: assert property ($rose(chargeEnable) |->
        $past(currentTargetWritten && inputPowerGood)) else $error("start");
    power_drop_a: assert property (!inputPowerGood |=>
        !chargeEnable) else $error("drop");
    low_staged_a: assert property (loWr |=>
        $stable(chargeVoltageTarget)) else $error("staged");
    cover property (clearCurrentTarget);
    cover property ($rose(chargeEnable));
    cover property (hiWr && hostWrite.data[7]);
endmodule : cvs_sva
bind cvs_charge_voltage_setpoint cvs_sva cvs_sva_i (.*);

//--- tb/tb.sv
// self-checking bench for the setpoint pair
`timescale 1ns/1ps
module tb;
    import cvs_pkg::*;
    logic clock = 1'b0;
    logic nrst;
    logic [2:0] cellCountStrap;
    logic [7:0] readAddr;
    logic inputPowerGood;
    logic currentTargetWritten;
    cvs_write_t hostWrite;
    logic [7:0] readData;
    logic [11:0] chargeVoltageTarget;
    logic [15:0] chargeVoltageMv;
    logic clearCurrentTarget;
    logic chargeEnable;
    int num_errors = 0;
    int compares = 0;
    always #50 clock = ~clock;
    cvs_host_model cvs_host_model_i (.clock(clock), .hostWrite(hostWrite));
    cvs_charge_voltage_setpoint cvs_charge_voltage_setpoint_i (
        .clock(clock), .nrst(nrst), .hostWrite(hostWrite),
        .readAddr(readAddr), .cellCountStrap(cellCountStrap),
        .inputPowerGood(inputPowerGood),
        .currentTargetWritten(currentTargetWritten), .readData(readData),
        .chargeVoltageTarget(chargeVoltageTarget),
        .chargeVoltageMv(chargeVoltageMv),
        .clearCurrentTarget(clearCurrentTarget), .chargeEnable(chargeEnable));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        readAddr = a;
        @(posedge clock);
        #1 chk({8'h00, readData}, {8'h00, e});
    endtask : rd
    task automatic pulse();
        @(posedge clock);
        #1 currentTargetWritten = 1'b1;
        @(posedge clock);
        #1 currentTargetWritten = 1'b0;
    endtask : pulse
    task automatic t_defaults();
        logic [15:0] e;
        for (int c = 0; c < 8; c++) begin
            nrst = 1'b0;
            cellCountStrap = 3'(c);
            // codes outside 1..5 fall back to one cell
            e = (c >= 1 && c <= 5) ? 16'(c * 4200) : 16'h1068;
            repeat (6) @(posedge clock);
            #1 nrst = 1'b1;
            repeat (2) @(posedge clock);
            #1 chk(chargeVoltageMv, e);
        end
    endtask : t_defaults
    task automatic t_default_charge();
        // no setpoint written since reset: default voltage is used
        inputPowerGood = 1'b1;
        pulse();
        chk({15'h0000, chargeEnable}, 16'h0001);
        chk(chargeVoltageMv, 16'h1068);
        inputPowerGood = 1'b0;
    endtask : t_default_charge
    task automatic t_limits();
        cvs_host_model_i.wv(16'h59df);
        chk(chargeVoltageMv, 16'h59d8);
        chk({4'h0, chargeVoltageTarget}, 16'h0b3b);
        rd(CVS_ADDR_LOW, 8'hd8);
        rd(CVS_ADDR_HIGH, 8'h59);
        rd(8'h06, 8'h00);
        cvs_host_model_i.wv(16'h59e0);
        chk(chargeVoltageMv, 16'h59d8);
        cvs_host_model_i.wv(16'h0400);
        chk(chargeVoltageMv, 16'h0400);
        cvs_host_model_i.wv(16'h03f8);
        chk(chargeVoltageMv, 16'h0400);
        cvs_host_model_i.wv(16'h8a00);
        chk({clearCurrentTarget, chargeVoltageMv[14:0]}, 16'h0400);
        // reserved bit with an all-zero field must not act as a zero write
        cvs_host_model_i.wv(16'h8000);
        chk({clearCurrentTarget, chargeVoltageMv[14:0]}, 16'h0400);
    endtask : t_limits
    task automatic t_weights();
        logic [11:0] f;
        for (int b = 5; b < 12; b++) begin
            f = 12'h080 | (12'h001 << b) | (12'h001 << (b - 5));
            cvs_host_model_i.wv({1'h0, f[11:5], f[4:0], 3'h0});
            // base 1024 mV ORed with the two bit weights of this step
            chk(chargeVoltageMv, 16'h0400 | (16'h0100 << (b - 5)) |
                (16'h0008 << (b - 5)));
        end
    endtask : t_weights
    task automatic t_charge();
        pulse();
        chk({15'h0000, chargeEnable}, 16'h0000);
        inputPowerGood = 1'b1;
        cvs_host_model_i.wv(16'h20d0);
        pulse();
        chk({15'h0000, chargeEnable}, 16'h0001);
        cvs_host_model_i.wv(16'h0000);
        chk({clearCurrentTarget, chargeEnable, chargeVoltageMv[13:0]},
            16'ha0d0);
        pulse();
        chk({15'h0000, chargeEnable}, 16'h0001);
        inputPowerGood = 1'b0;
        @(posedge clock);
        #1 chk({15'h0000, chargeEnable}, 16'h0000);
    endtask : t_charge
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    initial begin
        nrst = 1'b0;
        cellCountStrap = CVS_CELLS_1;
        readAddr = 8'h00;
        inputPowerGood = 1'b0;
        currentTargetWritten = 1'b0;
        t_defaults();
        t_default_charge();
        t_limits();
        t_weights();
        t_charge();
        end_of_test();
    end
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule : tb
